// ===== common/pin_state_map.svh
// offsets-free constant map: mode codes, reset timing and pin widths for the pin state block
`ifndef PIN_STATE_MAP_SVH
`define PIN_STATE_MAP_SVH
// ==========================================================
// operating mode codes on the three mode pins
`define MODE_W 3
`define MODE_SINGLE_LO 3'h6
`define MODE_SINGLE_HI 3'h7
`define MODE_EXP_UPPER 3'h5
// ==========================================================
// timing: address bus is driven low 2.5 clocks, rounded up to 3 whole clocks, after reset is seen low
`define ADDR_LOW_DELAY_HALF_CYCLES 5
`define ADDR_LOW_DELAY_CYCLES ((`ADDR_LOW_DELAY_HALF_CYCLES + 1) / 2)
`define CLOCK_PERIOD_NS 10
// ==========================================================
// pin widths
`define ADDR_W 24
`define DATA_W 16
`define CS_HI_W 4
`define UPPER_ADDR_W 3
`endif

// ===== common/pin_state_pkg.sv
// types shared by the pin state block: phases, pin groups, strobes and configuration
`include "pin_state_map.svh"
package pin_state_pkg;
   // ==========================================================
   // operating condition of the chip as seen at its pins
   typedef enum logic [2:0] {
      run_st,
      reset_st,
      hw_standby_st,
      sw_standby_st,
      bus_release_st
   } pin_phase_e;
   // one pin group: value, drive enable
   typedef struct packed {
      logic [`ADDR_W-1:0] value;
      logic [`ADDR_W-1:0] oe;
   } addr_pins_s;
   // the four bus strobes, active low
   typedef struct packed {
      logic addr_strobe_n;
      logic read_n;
      logic upper_write_n;
      logic lower_write_n;
   } strobes_s;
   // software-written configuration bits
   typedef struct packed {
      logic [`UPPER_ADDR_W-1:0] upper_addr_enable; // 23..21, 0 = address use
      logic addr20_enable;                         // 0 = address use
      logic [`CS_HI_W-1:0] chip_sel_pin_enable;    // 7..4, 1 = chip select use
      logic standby_outputs_hold;
      logic onchip_ram_enable;
   } config_s;
endpackage

// ===== design/pin_hold_cell.sv
// one pin with hold behaviour: float when input, keep last value when output
`timescale 1ns/1ps
`default_nettype none
module pin_hold_cell
   import pin_state_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic hold,
   input wire logic dir_out,
   input wire logic new_value,
   input wire logic new_oe,
   output logic pin_out,
   output logic pin_oe
);
   // ==========================================================
   // state record: last driven value
   typedef struct packed {
      logic last_q;
   } cell_s;
   cell_s s_q;
   cell_s s_d;
   // capture the driven value while not holding
   always_comb begin
      s_d = s_q;
      if (!hold && new_oe) begin
         s_d.last_q = new_value;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   // hold: inputs float, outputs keep their value
   always_comb begin
      if (hold) begin
         pin_out = s_q.last_q;
         pin_oe = dir_out;
      end else begin
         pin_out = new_value;
         pin_oe = new_oe;
      end
   end
   property hold_keeps_p;
      @(posedge clock) disable iff (rst)
      (hold && dir_out && $past(hold)) |-> (pin_out == $past(pin_out));
   endproperty
   hold_keeps_value_a: assert property (hold_keeps_p)
      else $error("held output pin changed value");
   hold_float_in_a: assert property (@(posedge clock) disable iff (rst)
      (hold && !dir_out) |-> !pin_oe)
      else $error("held input pin is driven");
endmodule
`default_nettype wire

// ===== design/pin_state_ctrl.sv
// pin state controller for bus, strobes, upper address and chip select pins
//
// Contract
// - ports go input at once on reset
// - modes 1-4: strobes, cs0 high, data floats
// - modes 1-4: address low 2.5 clocks later; code waits 3 clocks
// - modes 3-4: upper address, chip selects float
// - mode 5: strobes high, address, data float
// - clock pin drives at first edge after reset
// - no bus release in modes 6, 7
// - held pins: inputs float, outputs keep value
// - modes 3-5: PA6-4 address when enable 0
// - PA7 address 20 rules by mode
// - PB3-0 chip selects when enable bit 1
// - standby chip selects float or high; release float
// - reset output low only on watchdog, mask version
`timescale 1ns/1ps
`default_nettype none
`include "pin_state_map.svh"
module pin_state_ctrl
   import pin_state_pkg::*;
#(
   parameter bit MASK_ROM_VERSION = 1'b1 // reset output only exists in this build
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic chip_init_n,                       // reset pin, asynchronous
   input wire logic hw_standby_n,                      // standby pin, asynchronous
   input wire logic [`MODE_W-1:0] mode,                // mode pins, static
   input wire config_s cfg,                            // software configuration bits
   input wire logic sw_standby,                        // core is in software standby
   input wire logic bus_release_req,                   // bus release requested
   input wire logic watchdog_reset,                    // reset came from watchdog overflow
   input wire logic [`ADDR_W-1:0] core_addr,           // address from bus controller
   input wire strobes_s core_strobes,                  // strobes from bus controller
   input wire logic core_cs0_n,                        // chip select 0 from bus controller
   input wire logic [`CS_HI_W-1:0] core_cs_hi_n,       // chip selects 7..4
   input wire logic core_data_oe,                      // data bus drive request
   input wire logic [`UPPER_ADDR_W:0] port_a_value,    // PA7..PA4 port data
   input wire logic [`UPPER_ADDR_W:0] port_a_dir,      // PA7..PA4 direction, 1 = out
   input wire logic [`CS_HI_W-1:0] port_b_value,       // PB3..PB0 port data
   input wire logic [`CS_HI_W-1:0] port_b_dir,         // PB3..PB0 direction
   output logic bus_release_grant,
   output logic [`ADDR_W-1:0] addr_out,
   output logic [`ADDR_W-1:0] addr_oe,
   output strobes_s strobes_out,
   output logic strobes_oe,
   output logic cs0_n_out,
   output logic cs0_oe,
   output logic data_oe,
   output logic [`UPPER_ADDR_W:0] port_a_out,          // PA7..PA4
   output logic [`UPPER_ADDR_W:0] port_a_oe,
   output logic [`CS_HI_W-1:0] port_b_out,             // PB3..PB0
   output logic [`CS_HI_W-1:0] port_b_oe,
   output logic clock_pin_oe,
   output logic watchdog_init_out_n,
   output logic [2:0] phase
);
   // ==========================================================
   // pin synchronisers and state record
   typedef struct packed {
      logic [1:0] init_sync_q;      // reset pin, two stages
      logic [1:0] hw_standby_n_sync_q;      // standby pin, two stages
      logic [2:0] addr_cnt_q;       // cycles since reset sampled low
      logic addr_low_q;             // address bus forced low
      logic clk_oe_q;               // clock pin in output state
      logic grant_q;
      logic wdt_out_q;
   } ctrl_s;
   ctrl_s s_q;
   ctrl_s s_d;
   logic init_low;       // synchronised reset low
   logic hw_standby_n_low;       // synchronised standby low
   logic bus_modes;      // modes 1 to 5
   logic upper_modes;    // modes 3 to 5
   logic mode5;
   logic single_chip;
   logic in_reset;       // immediate, pin level
   logic in_hw_standby;  // immediate, pin level
   logic hold_pins;      // software standby or release keep behaviour
   logic [`UPPER_ADDR_W:0] pa_addr_use;
   logic [`CS_HI_W-1:0] pb_cs_use;
   logic [`UPPER_ADDR_W:0] pa_val;
   logic [`UPPER_ADDR_W:0] pa_oe;
   logic [`CS_HI_W-1:0] pb_val;
   logic [`CS_HI_W-1:0] pb_oe;
   logic [`UPPER_ADDR_W:0] pa_hold_out;
   logic [`UPPER_ADDR_W:0] pa_hold_oe;
   logic [`CS_HI_W-1:0] pb_hold_out;
   logic [`CS_HI_W-1:0] pb_hold_oe;
   assign init_low = !s_q.init_sync_q[1];
   assign hw_standby_n_low = !s_q.hw_standby_n_sync_q[1];
   // immediate reset and standby views come straight from the pins: standby only
   // gates enables off, but a reset glitch can also drive strobes, cs0 and the clock pin
   assign in_reset = !chip_init_n;
   assign in_hw_standby = !hw_standby_n;
   assign single_chip = (mode == `MODE_SINGLE_LO) || (mode == `MODE_SINGLE_HI);
   assign bus_modes = (mode != 3'h0) && !single_chip;
   assign upper_modes = bus_modes && (mode >= 3'h3);
   assign mode5 = (mode == `MODE_EXP_UPPER);
   // ==========================================================
   // pin function selection
   always_comb begin
      // PA6..PA4 address 23..21 when enable bit is 0
      pa_addr_use[2:0] = upper_modes ? ~cfg.upper_addr_enable : 3'h0;
      // PA7 address 20: always in modes 3, 4, by enable in mode 5
      pa_addr_use[3] = upper_modes && (mode5 ? !cfg.addr20_enable : 1'b1);
      // PB3..PB0 chip selects 7..4 when enable bit is 1
      // PB bit i carries chip select 7-i, so its enable is bit 3-i
      for (int i = 0; i < `CS_HI_W; i++) begin
         pb_cs_use[i] = bus_modes && cfg.chip_sel_pin_enable[3 - i];
      end
   end
   // ==========================================================
   // synchronisers, reset address delay, clock pin, release grant
   always_comb begin
      s_d = s_q;
      s_d.init_sync_q = {s_q.init_sync_q[0], chip_init_n};
      s_d.hw_standby_n_sync_q = {s_q.hw_standby_n_sync_q[0], hw_standby_n};
      // clock pin goes output at the first edge after reset goes low
      s_d.clk_oe_q = in_reset ? 1'b1 : s_q.clk_oe_q;
      if (init_low) begin
         // count from the cycle reset was sampled low
         if (s_q.addr_cnt_q != 3'(`ADDR_LOW_DELAY_CYCLES)) begin
            s_d.addr_cnt_q = s_q.addr_cnt_q + 3'h1;
         end
         s_d.addr_low_q = (s_q.addr_cnt_q + 3'h1) >= 3'(`ADDR_LOW_DELAY_CYCLES);
      end else begin
         s_d.addr_cnt_q = 3'h0;
         s_d.addr_low_q = 1'b0;
      end
      // release is never granted in single-chip modes
      s_d.grant_q = bus_release_req && bus_modes && !init_low && !hw_standby_n_low && !sw_standby;
      // reset output low only for a watchdog reset in the mask build
      s_d.wdt_out_q = MASK_ROM_VERSION && watchdog_reset;
   end
   // the reset pin is the controller's own reset stimulus; rst only clears state
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         // synchronisers start at the idle pin level: no false pin reset after rst
         s_q <= '{init_sync_q: 2'h3, hw_standby_n_sync_q: 2'h3, default: '0};
      end else begin
         s_q <= s_d;
      end
   end
   assign hold_pins = sw_standby || s_q.grant_q;
   // ==========================================================
   // pin drivers
   always_comb begin
      // run values
      pa_val = port_a_value;
      pa_oe = port_a_dir;
      pb_val = port_b_value;
      pb_oe = port_b_dir;
      for (int i = 0; i <= `UPPER_ADDR_W; i++) begin
         if (pa_addr_use[i]) begin
            // PA7 carries A20, PA6..PA4 carry A23..A21
            pa_val[i] = core_addr[(i == 3) ? 20 : 21 + i];
            pa_oe[i] = 1'b1;
         end
      end
      for (int i = 0; i < `CS_HI_W; i++) begin
         if (pb_cs_use[i]) begin
            pb_val[i] = core_cs_hi_n[3 - i];
            pb_oe[i] = 1'b1;
         end
      end
      addr_out = core_addr;
      addr_oe = bus_modes ? {`ADDR_W{1'b1}} : '0;
      strobes_out = core_strobes;
      strobes_oe = bus_modes;
      cs0_n_out = core_cs0_n;
      cs0_oe = bus_modes;
      data_oe = bus_modes && core_data_oe;
      if (s_q.grant_q) begin
         // released bus: address, strobes and active chip selects float
         addr_oe = '0;
         strobes_oe = 1'b0;
         cs0_oe = 1'b0;
         data_oe = 1'b0;
         pa_oe = pa_oe & ~pa_addr_use;
         pb_oe = pb_oe & ~pb_cs_use;
      end else if (sw_standby) begin
         data_oe = 1'b0;
         strobes_out = '1;
         strobes_oe = bus_modes && cfg.standby_outputs_hold;
         cs0_n_out = 1'b1;
         cs0_oe = bus_modes && cfg.standby_outputs_hold;
         // chip selects float or drive high by the hold bit
         for (int i = 0; i < `CS_HI_W; i++) begin
            if (pb_cs_use[i]) begin
               pb_val[i] = 1'b1;
               pb_oe[i] = cfg.standby_outputs_hold;
            end
         end
         if (!cfg.standby_outputs_hold) begin
            addr_oe = '0;
            pa_oe = pa_oe & ~pa_addr_use;
         end
      end
      if (in_reset) begin
         // ports to input at once, no clock needed
         pa_oe = '0;
         pb_oe = '0;
         data_oe = 1'b0;
         strobes_out = '1;
         cs0_n_out = 1'b1;
         // modes 1-4: strobes and cs0 high, data floats
         strobes_oe = bus_modes;
         cs0_oe = bus_modes && !mode5;
         // address low after the delay; mode 5 floats it
         addr_out = '0;
         addr_oe = (bus_modes && !mode5 && s_q.addr_low_q) ? {`ADDR_W{1'b1}} : '0;
         // modes 3, 4: address 23..21 float, address 20 stays low; PA and PB pins float as ports
         if (upper_modes && !mode5) begin
            addr_oe[23:21] = 3'h0;
         end
      end
   end
   // keep behaviour for software standby and release
   for (genvar g = 0; g <= `UPPER_ADDR_W; g++) begin : g_pa
      pin_hold_cell u_cell (
         .clock(clock),
         .rst(rst),
         // address pins are held too: in software standby with the hold bit set they keep the last address
         .hold(hold_pins && !in_reset),
         .dir_out(pa_oe[g]),
         .new_value(pa_val[g]),
         .new_oe(pa_oe[g]),
         .pin_out(pa_hold_out[g]),
         .pin_oe(pa_hold_oe[g])
      );
   end
   for (genvar g = 0; g < `CS_HI_W; g++) begin : g_pb
      pin_hold_cell u_cell (
         .clock(clock),
         .rst(rst),
         .hold(hold_pins && !pb_cs_use[g] && !in_reset),
         .dir_out(port_b_dir[g]),
         .new_value(pb_val[g]),
         .new_oe(pb_oe[g]),
         .pin_out(pb_hold_out[g]),
         .pin_oe(pb_hold_oe[g])
      );
   end
   // hardware standby floats the PA7..PA4, PB3..PB0 and clock pins
   assign port_a_out = pa_hold_out;
   assign port_a_oe = in_hw_standby ? '0 : pa_hold_oe;
   assign port_b_out = pb_hold_out;
   assign port_b_oe = in_hw_standby ? '0 : pb_hold_oe;
   assign bus_release_grant = s_q.grant_q;
   assign clock_pin_oe = s_q.clk_oe_q && !in_hw_standby;
   assign watchdog_init_out_n = !s_q.wdt_out_q;
   assign phase = in_hw_standby ? 3'h2 : in_reset ? 3'h1 : s_q.grant_q ? 3'h4 :
                  sw_standby ? 3'h3 : 3'h0;
   // ==========================================================
   // checks
   sequence reset_seen_s;
      !s_q.init_sync_q[1] && $past(s_q.init_sync_q[1]);
   endsequence
   property addr_low_p;
      @(posedge clock) disable iff (rst)
      (reset_seen_s and (mode == 3'h1) and !chip_init_n[*1]) ##3 !chip_init_n |->
         (addr_oe == {`ADDR_W{1'b1}}) && (addr_out == '0);
   endproperty
   addr_low_delay_a: assert property (addr_low_p)
      else $error("address bus not low after reset delay");
   reset_ports_in_a: assert property (@(posedge clock) disable iff (rst)
      !chip_init_n |-> (port_a_oe == '0) && (port_b_oe == '0) && !data_oe)
      else $error("port driven during reset");
   reset_strobes_a: assert property (@(posedge clock) disable iff (rst)
      (!chip_init_n && bus_modes) |-> strobes_oe && (strobes_out == '1))
      else $error("strobes not high during reset");
   mode5_float_a: assert property (@(posedge clock) disable iff (rst)
      (!chip_init_n && mode5) |-> (addr_oe == '0))
      else $error("mode 5 address driven during reset");
   clock_pin_on_a: assert property (@(posedge clock) disable iff (rst)
      (!chip_init_n && hw_standby_n) |=> (clock_pin_oe == hw_standby_n))
      else $error("clock pin not output after reset");
   no_release_single_a: assert property (@(posedge clock) disable iff (rst)
      single_chip |-> !bus_release_grant)
      else $error("bus released in single chip mode");
   standby_cs_high_a: assert property (@(posedge clock) disable iff (rst)
      (sw_standby && !s_q.grant_q && chip_init_n && hw_standby_n &&
       cfg.standby_outputs_hold && pb_cs_use[0]) |-> port_b_oe[0] && port_b_out[0])
      else $error("standby chip select not high");
   hw_standby_float_a: assert property (@(posedge clock) disable iff (rst)
      !hw_standby_n |-> (port_a_oe == '0) && (port_b_oe == '0))
      else $error("pin driven in hardware standby");
   upper_float_a: assert property (@(posedge clock) disable iff (rst)
      (!chip_init_n && upper_modes && !mode5) |-> (addr_oe[23:21] == 3'h0))
      else $error("upper address driven in reset");
   wdt_out_a: assert property (@(posedge clock) disable iff (rst)
      !watchdog_init_out_n |-> $past(watchdog_reset) && MASK_ROM_VERSION)
      else $error("reset output low without watchdog");
endmodule
`default_nettype wire

// ===== tb/ext_system_model.sv
// external system model that sequences the reset and hardware standby pins
`timescale 1ns/1ps
`default_nettype none
module ext_system_model (
   input wire logic clock,
   output logic chip_init_n,
   output logic hw_standby_n
);
   // ==========================================================
   // pin levels at time zero: neither reset nor standby asserted
   initial begin
      chip_init_n = 1'b1;
      hw_standby_n = 1'b1;
   end

   // ==========================================================
   // reset pin alone; changes land just after a rising edge
   task automatic hold_reset();
      @(posedge clock);
      #1 chip_init_n = 1'b0;
   endtask

   task automatic free_reset();
      @(posedge clock);
      #1 chip_init_n = 1'b1;
   endtask

   // entering standby: reset leads by 11 clocks only when on-chip ram is kept
   task automatic enter_standby(input bit ram_on);
      if (ram_on) begin
         @(posedge clock);
         #1 chip_init_n = 1'b0;
         repeat (10) @(posedge clock);
      end
      // with ram off no early reset is needed
      @(posedge clock);
      #1 hw_standby_n = 1'b0;
   endtask

   // leaving standby: reset low 100 ns ahead, held until standby is gone
   task automatic leave_standby();
      @(posedge clock);
      #1 chip_init_n = 1'b0;
      repeat (10) @(posedge clock);
      #1 hw_standby_n = 1'b1;
      // reset is only freed once standby has been seen high
      repeat (2) @(posedge clock);
      #1 chip_init_n = 1'b1;
   endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the pin state controller
`timescale 1ns/1ps
`default_nettype none
`include "pin_state_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
   $display("BAD t=%0t line %0d got %h exp %h", $time, `__LINE__, g, e); end end
module tb;
   import pin_state_pkg::*;
   // ==========================================================
   // stimulus and observed signals
   logic clock, rst, sw_standby, bus_release_req, watchdog_reset, core_cs0_n, core_data_oe;
   logic chip_init_n, hw_standby_n, bus_release_grant, strobes_oe, cs0_n_out, cs0_oe;
   logic data_oe, clock_pin_oe, watchdog_init_out_n;
   logic [`MODE_W-1:0] mode;
   logic [2:0] phase;
   config_s cfg;
   strobes_s core_strobes, strobes_out;
   logic [`ADDR_W-1:0] core_addr, addr_out, addr_oe;
   logic [3:0] core_cs_hi_n, port_a_value, port_a_dir, port_b_value, port_b_dir;
   logic [3:0] port_a_out, port_a_oe, port_b_out, port_b_oe;
   int err_count, cmp_count;
   // model expectations: e_ current, s_ saved before a hold phase
   logic [3:0] e_aoe, e_aout, e_ause, e_boe, e_bout, e_buse, s_aoe, s_aout, s_boe, s_bout;

   ext_system_model ext (.clock(clock), .chip_init_n(chip_init_n), .hw_standby_n(hw_standby_n));

   pin_state_ctrl dut (.clock(clock), .rst(rst), .chip_init_n(chip_init_n),
      .hw_standby_n(hw_standby_n), .mode(mode), .cfg(cfg), .sw_standby(sw_standby),
      .bus_release_req(bus_release_req), .watchdog_reset(watchdog_reset),
      .core_addr(core_addr), .core_strobes(core_strobes), .core_cs0_n(core_cs0_n),
      .core_cs_hi_n(core_cs_hi_n), .core_data_oe(core_data_oe),
      .port_a_value(port_a_value), .port_a_dir(port_a_dir), .port_b_value(port_b_value),
      .port_b_dir(port_b_dir), .bus_release_grant(bus_release_grant), .addr_out(addr_out),
      .addr_oe(addr_oe), .strobes_out(strobes_out), .strobes_oe(strobes_oe),
      .cs0_n_out(cs0_n_out), .cs0_oe(cs0_oe), .data_oe(data_oe), .port_a_out(port_a_out),
      .port_a_oe(port_a_oe), .port_b_out(port_b_out), .port_b_oe(port_b_oe),
      .clock_pin_oe(clock_pin_oe), .watchdog_init_out_n(watchdog_init_out_n), .phase(phase));

   // ==========================================================
   // 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // inputs always move 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // fresh random bus and port traffic
   task automatic randomise();
      core_addr = 24'($urandom);
      cfg = config_s'(10'($urandom));
      core_strobes = strobes_s'(4'($urandom));
      {core_cs0_n, core_data_oe, core_cs_hi_n} = 6'($urandom);
      {port_a_value, port_a_dir, port_b_value, port_b_dir} = 16'($urandom);
   endtask

   // ==========================================================
   // program execution pin map: PA7 is A20, PA6..PA4 are A23..A21, PB i is CS(7-i)
   task automatic model(input int m);
      for (int i = 0; i < 4; i++) begin
         e_ause[i] = (i == 3) ? (m == 3 || m == 4 || (m == 5 && !cfg.addr20_enable))
                              : (m >= 3 && m <= 5 && !cfg.upper_addr_enable[i]);
         e_aoe[i] = e_ause[i] | port_a_dir[i];
         e_aout[i] = e_ause[i] ? core_addr[(i == 3) ? 20 : 21 + i] : port_a_value[i];
         e_buse[i] = m <= 5 && cfg.chip_sel_pin_enable[3 - i];
         e_boe[i] = e_buse[i] | port_b_dir[i];
         e_bout[i] = e_buse[i] ? core_cs_hi_n[3 - i] : port_b_value[i];
      end
   endtask

   // compare enables, and levels only where a pin is driven
   task automatic chk();
      `CHK(port_a_oe, e_aoe)
      `CHK(port_a_out & e_aoe, e_aout & e_aoe)
      `CHK(port_b_oe, e_boe)
      `CHK(port_b_out & e_boe, e_bout & e_boe)
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ==========================================================
   // hang guard: a full run is well under 2000 cycles
   initial begin
      #50000;
      err_count++;
      $display("BAD t=%0t run did not finish", $time);
      give_verdict();
   end

   // ==========================================================
   // main sequence: modes 1 to 7 each walk run, release, soft standby, hard standby, reset
   initial begin
      void'($urandom(32));
      err_count = 0;
      cmp_count = 0;
      rst = 1'b1;
      mode = 3'h1;
      {sw_standby, bus_release_req, watchdog_reset} = 3'h0;
      randomise();
      repeat (3) @(posedge clock);
      #1 rst = 1'b0;
      for (int m = 1; m <= 7; m++) begin
         mode = m[2:0];
         randomise();
         step(2);
         model(m);
         chk();
         {s_aoe, s_aout, s_boe, s_bout} = {e_aoe, e_aout, e_boe, e_bout};
         // release is refused in single-chip modes; granted pins float
         bus_release_req = 1'b1;
         step(2);
         `CHK(bus_release_grant, 1'(m <= 5))
         if (m <= 5) begin
            `CHK(phase, 3'h4)
            e_aoe = s_aoe & ~e_ause;
            e_boe = s_boe & ~e_buse;
         end
         chk();
         bus_release_req = 1'b0;
         step(2);
         // soft standby with both hold settings; inputs move but pins must not follow them
         for (int h = 0; h < 2; h++) begin
            cfg.standby_outputs_hold = h[0];
            sw_standby = 1'b1;
            step(1);
            {port_a_value, port_b_value, core_cs_hi_n} = ~{port_a_value, port_b_value, core_cs_hi_n};
            core_addr = ~core_addr;
            step(2);
            e_aoe = h[0] ? s_aoe : s_aoe & ~e_ause;
            e_aout = s_aout;
            e_boe = h[0] ? s_boe : s_boe & ~e_buse;
            e_bout = h[0] ? s_bout | e_buse : s_bout;
            chk();
            `CHK(phase, 3'h3)
            sw_standby = 1'b0;
            {port_a_value, port_b_value, core_cs_hi_n} = ~{port_a_value, port_b_value, core_cs_hi_n};
            core_addr = ~core_addr;
            step(2);
         end
         // hardware standby floats the PA, PB and clock pins whatever the config
         ext.enter_standby(cfg.onchip_ram_enable);
         step(1);
         `CHK({port_a_oe, port_b_oe}, 8'h00)
         `CHK(clock_pin_oe, 1'b0)
         `CHK(phase, 3'h2)
         ext.leave_standby();
         step(2);
         // reset during traffic: asynchronous effects first
         ext.hold_reset();
         #1;
         `CHK({port_a_oe, port_b_oe, data_oe}, 9'h000)
         if (m <= 5) `CHK({strobes_out, strobes_oe}, 5'h1F)
         if (m <= 4) `CHK({cs0_n_out, cs0_oe}, 2'h3)
         if (m == 5) `CHK(addr_oe, 24'h000000)
         step(1);
         `CHK(clock_pin_oe, 1'b1)
         step(5);
         if (m <= 4) `CHK({addr_oe, addr_out}, {((m >= 3) ? 24'h1FFFFF : 24'hFFFFFF), 24'h000000})
         `CHK(watchdog_init_out_n, 1'b1)
         watchdog_reset = 1'b1;
         step(3);
         `CHK(watchdog_init_out_n, 1'b0)
         watchdog_reset = 1'b0;
         ext.free_reset();
         step(3);
         `CHK(watchdog_init_out_n, 1'b1)
         $display("mode %0d test done", m);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
